// ===== verilog/ext_bus_pkg.sv
// Constants shared by the external bus pin interface and its helpers.
// Assumes a 32-bit APB register bus and a single 100 MHz clock domain.
//
// Contract
// R01 - Read strobe goes low for every external instruction fetch or data read.
// R02 - Write strobe mode bit: whole-word pulses every write; low-byte mode low writes only.
// R03 - High-byte pin is byte enable or high-byte write strobe, per write mode.
// R04 - Wait input polarity programmable; inactive level adds wait states until active.
// R05 - Address latch enable lets outside logic capture multiplexed address.
// R06 - Boot select low during and after reset means boot from external memory.
// R07 - Low port carries data in demux modes, address/data in mux modes.
// R08 - Segment lines A16..A23 appear on the eight segment pins, LSB first.
// R09 - Upper four segment pins switch between address and CAN receive/transmit.
// R10 - Each bus pin has a direction bit; input pins are never driven.
// R11 - A clock output pin carries the system clock at CPU frequency.
// R12 - Address-only port outputs address in demux mode and after demux-to-mux switch.
// R13 - Any CAN controller in use limits segment addressing to four lines.
// R14 - Read and write strobes stay high outside external accesses.
package ext_bus_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIR0 = 8'h04;
  localparam logic [7:0] OFS_DIR1 = 8'h08;
  localparam logic [7:0] OFS_DIR4 = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_WDATA = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_RDATA = 8'h20;
  localparam logic [7:0] OFS_PINS = 8'h24;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_WRMODE = 0;
  localparam int CTRL_MUX = 1;
  localparam int CTRL_BUS16 = 2;
  localparam int CTRL_RDYEN = 3;
  localparam int CTRL_RDYPOL = 4;
  localparam int CTRL_SEGEN = 5;
  localparam int CTRL_CANA = 6;
  localparam int CTRL_CANB = 7;
  localparam int CTRL_SYS_CLOCK_OUT = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // Command register fields
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_BE_LSB = 2;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_BOOTEXT = 1;
  localparam int ST_READY = 2;
  localparam int ST_P1KEEP = 3;

  // Pin snapshot register fields
  localparam int PINS_P4_LSB = 16;

  // ------------------------------------------------------------------
  // Reset values and timing counts
  // ------------------------------------------------------------------
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [2:0] STROBE_MIN_CYCLES = 3'h3;
  localparam logic [1:0] BOOT_CAPTURE_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_READ,
    KIND_WRITE,
    KIND_FETCH
  } access_kind_t;

endpackage

// ===== verilog/sync_2ff.sv
// Two-flop synchroniser for levels that arrive from pins.
// Assumes the input is quasi-static relative to a few mclk periods.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] stable_ff;

  // First stage is read only by the second stage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      stable_ff <= RST_VAL;
    end else begin
      meta_ff <= async;
      stable_ff <= meta_ff;
    end
  end

  assign synced = stable_ff;

endmodule
`default_nettype wire

// ===== verilog/seg_port_mux.sv
// Segment address port: shares its upper pins with two CAN controllers.
// Assumes segment address and enables come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module seg_port_mux (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] segAddr,
  input wire logic segEn,
  input wire logic canAEn,
  input wire logic canBEn,
  input wire logic canATx,
  input wire logic canBTx,
  input wire logic [7:0] dir,
  output logic [7:0] segOut,
  output logic [7:0] segOe
);

  logic [7:0] nxt_out;
  logic [7:0] nxt_oe;
  logic canAny;

  assign canAny = canAEn | canBEn;

  // Pin function per bit; CAN use takes the upper half
  always_comb begin
    nxt_out = segAddr; // [R08]
    nxt_oe = {8{segEn}};
    if (canAny) begin
      nxt_oe[7:4] = 4'h0; // [R13]
    end
    if (canBEn) begin
      nxt_out[7] = canBTx; // [R09]
      nxt_oe[7] = 1'b1;
    end
    if (canAEn) begin
      nxt_out[6] = canATx; // [R09]
      nxt_oe[6] = 1'b1;
    end
    nxt_oe = nxt_oe & dir; // [R10]
  end

  // Registered so the pins never see decode glitches
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      segOut <= 8'h00;
      segOe <= 8'h00;
    end else begin
      segOut <= nxt_out;
      segOe <= nxt_oe;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/ext_bus_if.sv
// External memory bus pin interface with APB control and status.
// Assumes an APB master on mclk and asynchronous pins on the bus side.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_if
  import ext_bus_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus strobes
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic highByteN,
  output logic addrLatchEn,
  input wire logic readyIn,
  input wire logic externalBootSelectN,
  output logic bootFromExternal,
  output logic sysClockOut,
  // Multiplexed address/data port
  input wire logic [15:0] addrDataIn,
  output logic [15:0] addrDataOut,
  output logic [15:0] addrDataOe,
  // Address-only port
  input wire logic [15:0] addressOnlyIn,
  output logic [15:0] addressOnlyOut,
  output logic [15:0] addressOnlyOe,
  // Segment / CAN port
  input wire logic [7:0] segPortIn,
  output logic [7:0] segPortOut,
  output logic [7:0] segPortOe,
  // CAN controller side
  input wire logic canATx,
  input wire logic canBTx,
  output logic canARx,
  output logic canBRx
);

  typedef enum logic [1:0] {
    S_IDLE,
    S_ADDR,
    S_STROBE,
    S_HOLD
  } bus_state_t;

  // ------------------------------------------------------------------
  // Registers and synchronised pins
  // ------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_ff;
  logic [15:0] dir0_ff, dir1_ff;
  logic [7:0] dir4_ff;
  logic [23:0] addr_ff;
  logic [15:0] wdata_ff, rdata_ff;
  access_kind_t kind_ff;
  logic [1:0] be_ff, bootCnt_ff;
  bus_state_t state_ff;
  logic [2:0] strobeCnt_ff;
  logic p1Keep_ff, clkOutEn_ff;
  logic readySync, bootSelSync;
  logic [15:0] adSync, p1Sync;
  logic [7:0] p4Sync;

  sync_2ff #(.W(1), .RST_VAL(1'b0)) u_sync_ready (
    .mclk(mclk),
    .nrst(nrst),
    .async(readyIn),
    .synced(readySync)
  );

  sync_2ff #(.W(1), .RST_VAL(1'b1)) u_sync_boot (
    .mclk(mclk),
    .nrst(nrst),
    .async(externalBootSelectN),
    .synced(bootSelSync)
  );

  sync_2ff #(.W(40), .RST_VAL(40'h00_0000_0000)) u_sync_ports (
    .mclk(mclk),
    .nrst(nrst),
    .async({segPortIn, addressOnlyIn, addrDataIn}),
    .synced({p4Sync, p1Sync, adSync})
  );

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  logic setup, wrTake, mapped, busy;
  logic [31:0] nxt_rdata;
  assign setup = psel & ~penable;
  assign wrTake = psel & penable & pready & pwrite;
  assign busy = (state_ff != S_IDLE);

  // Read mux, evaluated in the setup cycle so data is ready at access
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      OFS_CTRL: nxt_rdata[CTRL_W-1:0] = ctrl_ff;
      OFS_DIR0: nxt_rdata[15:0] = dir0_ff;
      OFS_DIR1: nxt_rdata[15:0] = dir1_ff;
      OFS_DIR4: nxt_rdata[7:0] = dir4_ff;
      OFS_ADDR: nxt_rdata[23:0] = addr_ff;
      OFS_WDATA: nxt_rdata[15:0] = wdata_ff;
      OFS_CMD: nxt_rdata[3:0] = {be_ff, kind_ff};
      OFS_STATUS: begin
        nxt_rdata[ST_BUSY] = busy;
        nxt_rdata[ST_BOOTEXT] = bootFromExternal;
        nxt_rdata[ST_READY] = readySync;
        nxt_rdata[ST_P1KEEP] = p1Keep_ff;
      end
      OFS_RDATA: nxt_rdata[15:0] = rdata_ff;
      OFS_PINS: nxt_rdata = {8'h00, p4Sync, p1Sync};
      default: mapped = 1'b0;
    endcase
  end

  // One wait-free answer: pready rises in the first access cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= nxt_rdata;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RESET;
      dir0_ff <= DIR_RESET;
      dir1_ff <= DIR_RESET;
      dir4_ff <= DIR_RESET[7:0];
      addr_ff <= 24'h00_0000;
      wdata_ff <= 16'h0000;
    end else if (wrTake) begin
      unique case (paddr)
        OFS_CTRL: ctrl_ff <= pwdata[CTRL_W-1:0]; // [R02] [R04]
        OFS_DIR0: dir0_ff <= pwdata[15:0]; // [R10]
        OFS_DIR1: dir1_ff <= pwdata[15:0]; // [R10]
        OFS_DIR4: dir4_ff <= pwdata[7:0]; // [R10]
        OFS_ADDR: addr_ff <= pwdata[23:0];
        OFS_WDATA: wdata_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Boot source capture and clock output
  // ------------------------------------------------------------------
  // Caught after the synchroniser has filled with post-reset samples
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bootCnt_ff <= 2'h0;
      bootFromExternal <= 1'b0;
    end else if (bootCnt_ff != BOOT_CAPTURE_CYCLES + 2'h1) begin
      bootCnt_ff <= bootCnt_ff + 2'h1;
      bootFromExternal <= ~bootSelSync; // [R06]
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clkOutEn_ff <= 1'b0;
    end else begin
      clkOutEn_ff <= ctrl_ff[CTRL_SYS_CLOCK_OUT];
    end
  end

  // Gated by the high phase of mclk; enable changes only at rising edges
  assign sysClockOut = mclk & clkOutEn_ff; // [R11]

  // ------------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------------
  logic cmdStart, readyOk;
  assign cmdStart = wrTake && (paddr == OFS_CMD) && !busy &&
                    (pwdata[CMD_KIND_LSB+1:CMD_KIND_LSB] != 2'h0);
  assign readyOk = ~ctrl_ff[CTRL_RDYEN] | (readySync == ctrl_ff[CTRL_RDYPOL]); // [R04]

  // A command written while busy is dropped; status shows busy
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= S_IDLE;
      kind_ff <= KIND_NONE;
      be_ff <= 2'h0;
      strobeCnt_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (cmdStart) begin
            kind_ff <= access_kind_t'(pwdata[CMD_KIND_LSB+1:CMD_KIND_LSB]);
            be_ff <= pwdata[CMD_BE_LSB+1:CMD_BE_LSB];
            state_ff <= S_ADDR;
          end
        end
        S_ADDR: begin
          strobeCnt_ff <= 3'h0;
          state_ff <= S_STROBE;
        end
        S_STROBE: begin
          if (strobeCnt_ff != STROBE_MIN_CYCLES) begin
            strobeCnt_ff <= strobeCnt_ff + 3'h1;
          end else if (readyOk) begin
            state_ff <= S_HOLD; // [R04]
          end
        end
        S_HOLD: state_ff <= S_IDLE;
      endcase
    end
  end

  // Read data is sampled as the strobe ends
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_ff <= 16'h0000;
    end else if (state_ff == S_STROBE && strobeCnt_ff == STROBE_MIN_CYCLES &&
                 readyOk && kind_ff != KIND_WRITE) begin
      rdata_ff <= ctrl_ff[CTRL_BUS16] ? adSync : {8'h00, adSync[7:0]};
    end
  end

  // Address port keeps the address once a demultiplexed mode was used
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      p1Keep_ff <= 1'b0;
    end else if (!ctrl_ff[CTRL_MUX]) begin
      p1Keep_ff <= 1'b1; // [R12]
    end
  end

  // ------------------------------------------------------------------
  // Pin drive, computed next-cycle and registered
  // ------------------------------------------------------------------
  bus_state_t nxt_state;
  logic nxt_active, isWrite, isRead, lowByteWr, highByteWr;
  logic nxt_ale, nxt_rd, nxt_wr, nxt_hb;
  logic [15:0] nxt_adOut, nxt_adOe;

  // Next state mirror so pins line up with the sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: nxt_state = cmdStart ? S_ADDR : S_IDLE;
      S_ADDR: nxt_state = S_STROBE;
      S_STROBE: begin
        if (strobeCnt_ff == STROBE_MIN_CYCLES && readyOk) begin
          nxt_state = S_HOLD;
        end
      end
      S_HOLD: nxt_state = S_IDLE;
    endcase
  end

  access_kind_t kindNow;
  logic [1:0] beNow;
  assign kindNow = (state_ff == S_IDLE) ?
                   access_kind_t'(pwdata[CMD_KIND_LSB+1:CMD_KIND_LSB]) : kind_ff;
  assign beNow = (state_ff == S_IDLE) ? pwdata[CMD_BE_LSB+1:CMD_BE_LSB] : be_ff;
  assign nxt_active = (nxt_state != S_IDLE);
  assign isWrite = (kindNow == KIND_WRITE);
  assign isRead = (kindNow == KIND_READ) || (kindNow == KIND_FETCH);
  assign lowByteWr = isWrite & (beNow[0] | ~ctrl_ff[CTRL_BUS16]);
  assign highByteWr = isWrite & beNow[1] & ctrl_ff[CTRL_BUS16];

  // Strobe decode; read, write and high-byte strobes rest high and ALE rests low when no access runs
  always_comb begin
    nxt_ale = ctrl_ff[CTRL_MUX] && (nxt_state == S_ADDR); // [R05]
    nxt_rd = ~((nxt_state == S_STROBE) & isRead); // [R01] [R14]
    nxt_wr = 1'b1;
    nxt_hb = 1'b1;
    if (ctrl_ff[CTRL_WRMODE]) begin
      nxt_wr = ~((nxt_state == S_STROBE) & lowByteWr); // [R02]
      nxt_hb = ~((nxt_state == S_STROBE) & highByteWr); // [R03]
    end else begin
      nxt_wr = ~((nxt_state == S_STROBE) & isWrite); // [R02] [R14]
      nxt_hb = ~(nxt_active & beNow[1] & ctrl_ff[CTRL_BUS16]); // [R03]
    end
  end

  // Low port: address phase then data phase, per mux and width mode
  always_comb begin
    nxt_adOut = 16'h0000;
    nxt_adOe = 16'h0000;
    if (ctrl_ff[CTRL_MUX] && nxt_state == S_ADDR) begin
      nxt_adOut = addr_ff[15:0]; // [R07]
      nxt_adOe = 16'hffff;
    end else if (nxt_state == S_STROBE || nxt_state == S_HOLD) begin
      if (isWrite) begin
        nxt_adOut = wdata_ff; // [R07]
        nxt_adOe = ctrl_ff[CTRL_BUS16] ? 16'hffff : 16'h00ff;
      end
      if (ctrl_ff[CTRL_MUX] && !ctrl_ff[CTRL_BUS16]) begin
        nxt_adOut[15:8] = addr_ff[15:8]; // [R07]
        nxt_adOe[15:8] = 8'hff;
      end
    end
    nxt_adOe = nxt_adOe & dir0_ff; // [R10]
  end

  // Registered pin outputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
      highByteN <= 1'b1;
      addrLatchEn <= 1'b0;
      addrDataOut <= 16'h0000;
      addrDataOe <= 16'h0000;
      addressOnlyOut <= 16'h0000;
      addressOnlyOe <= 16'h0000;
    end else begin
      readStrobeN <= nxt_rd;
      writeStrobeN <= nxt_wr;
      highByteN <= nxt_hb;
      addrLatchEn <= nxt_ale;
      addrDataOut <= nxt_adOut;
      addrDataOe <= nxt_adOe;
      addressOnlyOut <= addr_ff[15:0]; // [R12]
      addressOnlyOe <= {16{~ctrl_ff[CTRL_MUX] | p1Keep_ff}} & dir1_ff; // [R12] [R10]
    end
  end

  // ------------------------------------------------------------------
  // Segment port and CAN receive path
  // ------------------------------------------------------------------
  seg_port_mux u_seg (
    .mclk(mclk),
    .nrst(nrst),
    .segAddr(addr_ff[23:16]),
    .segEn(ctrl_ff[CTRL_SEGEN]),
    .canAEn(ctrl_ff[CTRL_CANA]),
    .canBEn(ctrl_ff[CTRL_CANB]),
    .canATx(canATx),
    .canBTx(canBTx),
    .dir(dir4_ff),
    .segOut(segPortOut),
    .segOe(segPortOe)
  );

  // Receive pins idle recessive-high when their controller is off
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      canARx <= 1'b1;
      canBRx <= 1'b1;
    end else begin
      canARx <= ctrl_ff[CTRL_CANA] ? p4Sync[5] : 1'b1; // [R09]
      canBRx <= ctrl_ff[CTRL_CANB] ? p4Sync[4] : 1'b1; // [R09]
    end
  end

endmodule
`default_nettype wire

// ===== verification/ext_bus_if_assertions.sv
// Concurrent checks on the ext_bus_if pins.
// Assumes one mclk domain and a synchronous active-low nrst.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_if_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic highByteN,
  input wire logic addrLatchEn,
  input wire logic [15:0] addrDataOut,
  input wire logic [15:0] addrDataOe,
  input wire logic [7:0] segPortOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // Strobe and latch timing
  // ------------------------------------------------------------
  AST_STROBE_EXCL: assert property (readStrobeN || writeStrobeN)
    else $error("strobes overlap");
  AST_READ_MIN: assert property ($fell(readStrobeN) |-> !readStrobeN [*4])
    else $error("short read strobe");
  AST_READ_END: assert property ($fell(readStrobeN) |-> ##[4:100] $rose(readStrobeN))
    else $error("read strobe never released");
  AST_WRITE_MIN: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*4])
    else $error("short write strobe");
  // Data must outlive the strobe edge
  AST_WRITE_HOLD: assert property ($rose(writeStrobeN) |-> $stable(addrDataOut))
    else $error("write data moved");
  AST_ALE_ADDR: assert property (addrLatchEn |-> readStrobeN && writeStrobeN ##1 !addrLatchEn)
    else $error("bad latch pulse");
  AST_ALE_STROBE: assert property (addrLatchEn |=> !readStrobeN || !writeStrobeN || !highByteN)
    else $error("no strobe after latch pulse");
  AST_READ_INPUT: assert property (!readStrobeN |-> addrDataOe[7:0] == 8'h00)
    else $error("low port driven in read");
  AST_RESET_IDLE: assert property ($rose(nrst) |->
      readStrobeN && writeStrobeN && addrDataOe == 16'h0000 && segPortOe == 8'h00)
    else $error("pins not idle after reset");
  COV_READ: cover property ($fell(readStrobeN));
  COV_WRITE: cover property ($fell(writeStrobeN));
  COV_ALE: cover property (addrLatchEn);
  COV_HIGH_ONLY: cover property ($fell(highByteN) && writeStrobeN);
endmodule
`default_nettype wire

// ===== verification/ext_mem_model.sv
// External memory and ready source on the far side of the bus pins.
// Assumes no other driver on the low port.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic mclk,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic highByteN,
  input wire logic [15:0] addrDataOut,
  input wire logic [15:0] addrDataOe,
  input wire logic [15:0] memData,
  input wire logic [7:0] waitN,
  input wire logic readyPol,
  output logic [15:0] addrDataIn,
  output logic readyIn,
  output logic [15:0] lastWrite
);
  logic [15:0] noise = 16'h5a5a;
  logic [7:0] waitCnt = 8'h00;
  // Released wire toggles so stale data never passes for a read
  always @(posedge mclk) noise <= ~noise;
  // Memory answers only while the read strobe is low
  assign addrDataIn = (addrDataOe & addrDataOut) |
                      (~addrDataOe & (!readStrobeN ? memData : noise));
  // Ready inactive for waitN strobe cycles
  assign readyIn = (waitCnt >= waitN) ? readyPol : !readyPol;
  // Strobe cycle count; last driven word wins
  always @(posedge mclk) begin
    waitCnt <= (readStrobeN && writeStrobeN) ? 8'h00 : waitCnt + 8'h01;
    if (readStrobeN && (!writeStrobeN || !highByteN) && addrDataOe != 16'h0000) begin
      lastWrite <= addrDataOut;
    end
  end
endmodule
`default_nettype wire

// ===== verification/external_bus_pin_interface_test.sv
// Self-checking bench for ext_bus_if.
// Assumes one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_interface_test;
  import ext_bus_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, segIn = 8'h00, waitN = 8'h00, segSeen;
  logic [31:0] pwdata = 32'h0, prdata, addr, wd;
  logic pready, pslverr, readStrobeN, writeStrobeN, highByteN, addrLatchEn, readyIn;
  logic bootN = 1'b0, bootFromExternal, sysClockOut, canATx = 1'b0, canBTx = 1'b0;
  logic canARx, canBRx, readyPol = 1'b0, wrSeen, hbSeen, oeSeen;
  logic [15:0] addrDataIn, addrDataOut, addrDataOe, addressOnlyOut, addressOnlyOe;
  logic [15:0] memData = 16'h0, lastWrite, aleAddr, pinAddr, msk;
  logic [7:0] segPortIn, segPortOut, segPortOe;
  logic [32:0] expD[$], expM[$];
  logic [1:0] be;
  int numErrors = 0, nChecks = 0, aleCnt, rdLen;
  always #5 mclk = ~mclk;
  // Released segment pins read segIn
  assign segPortIn = (segPortOe & segPortOut) | (~segPortOe & segIn);
  ext_bus_if dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .highByteN(highByteN),
    .addrLatchEn(addrLatchEn), .readyIn(readyIn), .externalBootSelectN(bootN),
    .bootFromExternal(bootFromExternal), .sysClockOut(sysClockOut),
    .addrDataIn(addrDataIn), .addrDataOut(addrDataOut), .addrDataOe(addrDataOe),
    .addressOnlyIn(~addressOnlyOut), .addressOnlyOut(addressOnlyOut),
    .addressOnlyOe(addressOnlyOe), .segPortIn(segPortIn), .segPortOut(segPortOut),
    .segPortOe(segPortOe), .canATx(canATx), .canBTx(canBTx), .canARx(canARx),
    .canBRx(canBRx));
  ext_mem_model mem (.mclk(mclk), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .highByteN(highByteN), .addrDataOut(addrDataOut), .addrDataOe(addrDataOe),
    .memData(memData), .waitN(waitN), .readyPol(readyPol), .addrDataIn(addrDataIn),
    .readyIn(readyIn), .lastWrite(lastWrite));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic testDone();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Oldest note is checked at each APB read
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("apb read", {pslverr, prdata} & expM[0], expD[0]);
      void'(expD.pop_front());
      void'(expM.pop_front());
    end
  end
  // Pin observation; counts and seen flags cleared before each access
  always @(posedge mclk) begin
    if (addrLatchEn) begin
      aleCnt++;
      aleAddr = addrDataOut;
    end
    if (!readStrobeN) rdLen++;
    if (!readStrobeN || !writeStrobeN) begin
      pinAddr = addressOnlyOut;
      segSeen = segPortOut;
    end
    if (!writeStrobeN) wrSeen = 1'b1;
    if (!highByteN) hbSeen = 1'b1;
    if (addrDataOe != 16'h0000) oeSeen = 1'b1;
  end
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      numErrors++;
      testDone();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    logic [31:0] x;
    expD.push_back(e);
    expM.push_back(m);
    apb(1'b0, a, 32'h0, x);
  endtask
  // Start an access, then poll busy with masked notes
  task automatic access(input logic [31:0] cmd);
    logic [31:0] x;
    int i;
    aleCnt = 0;
    rdLen = 0;
    wrSeen = 1'b0;
    hbSeen = 1'b0;
    oeSeen = 1'b0;
    wr(OFS_CMD, cmd);
    for (i = 0; i < 100; i++) begin
      expD.push_back(33'h0);
      expM.push_back(33'h0);
      apb(1'b0, OFS_STATUS, 32'h0, x);
      if (x[ST_BUSY] === 1'b0) break;
    end
    if (i >= 100) begin
      numErrors++;
      testDone();
    end
  endtask
  task automatic doReset(input logic b);
    nrst <= 1'b0;
    bootN <= b;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    numErrors++;
    testDone();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(57));
    doReset(1'b0);
    check("boot", bootFromExternal, 1'b1);
    rd(OFS_CTRL, 33'h0, {33{1'b1}});
    rd(OFS_STATUS, 33'h2, 33'h100000003);
    rd(8'h40, 33'h100000000, {33{1'b1}});
    // Undirected pins stay released
    wr(OFS_CTRL, 32'h6);
    access(32'hd);
    check("oe off", oeSeen, 1'b0);
    check("read len", rdLen, STROBE_MIN_CYCLES + 1);
    wr(OFS_DIR0, 32'hffff);
    wr(OFS_DIR1, 32'hffff);
    wr(OFS_DIR4, 32'hff);
    // Demux modes first: address port stays owned
    for (int m = 0; m < 8; m++) begin
      addr = $urandom & 32'hffffff;
      wd = $urandom;
      be = 2'd1 + 2'($urandom % 3);
      msk = {(m[1] & be[1]) ? 8'hff : 8'h00, be[0] ? 8'hff : 8'h00};
      wr(OFS_CTRL, {26'h0, 1'b1, 2'b0, m[1], m[2], m[0]});
      wr(OFS_ADDR, addr);
      wr(OFS_WDATA, wd);
      access({28'h0, be, 2'd2});
      check("write strobe", wrSeen, m[0] ? (be[0] | !m[1]) : 1'b1);
      check("high byte", hbSeen, be[1] & m[1]);
      check("write data", lastWrite & msk, wd[15:0] & msk);
      check("latch count", aleCnt, m[2]);
      if (m[2]) check("latched addr", aleAddr, addr[15:0]);
      check("addr port", pinAddr, addr[15:0]);
      check("segment", segSeen, addr[23:16]);
      memData <= 16'($urandom);
      access(32'hd);
      rd(OFS_RDATA, {17'h0, m[1] ? memData[15:8] : 8'h00, memData[7:0]}, {33{1'b1}});
    end
    // Wait input stretches the read strobe
    waitN <= 8'd8;
    for (int p = 0; p < 2; p++) begin
      readyPol <= p[0];
      wr(OFS_CTRL, 32'he | (p << CTRL_RDYPOL));
      access(32'hd);
      check("wait states", rdLen >= 10, 1'b1);
    end
    waitN <= 8'd0;
    // Both CAN controllers on
    wr(OFS_CTRL, 32'he0);
    canATx <= 1'($urandom);
    canBTx <= 1'($urandom);
    segIn <= 8'($urandom);
    repeat (5) @(posedge mclk);
    check("can tx", segPortOut[7:6], {canBTx, canATx});
    check("can oe", segPortOe[7:4], 4'b1100);
    check("can rx", {canBRx, canARx}, {segIn[4], segIn[5]});
    check("four lines", segPortOut[3:0], addr[19:16]);
    // Clock out once enabled
    #2;
    check("clock off", sysClockOut, 1'b0);
    @(posedge mclk);
    wr(OFS_CTRL, 32'h100);
    #2;
    check("clock high", sysClockOut, 1'b1);
    #5;
    check("clock low", sysClockOut, 1'b0);
    @(posedge mclk);
    doReset(1'b1);
    check("boot flash", bootFromExternal, 1'b0);
    rd(OFS_STATUS, 33'h0, 33'h100000002);
    testDone();
  end
endmodule
bind ext_bus_if ext_bus_if_checker chk (.mclk(mclk), .nrst(nrst),
  .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .highByteN(highByteN),
  .addrLatchEn(addrLatchEn), .addrDataOut(addrDataOut), .addrDataOe(addrDataOe),
  .segPortOe(segPortOe));
`default_nettype wire
